// ===== apw_top.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module apw_top
   import apw_pkg::*;
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Non-volatile trim value
   input wire logic [5:0] nvm_trim,
   // Outputs
   output logic periodic_irq,
   output logic periodic_wave_pin
);
   ////////////////////////////////////////////////////////////////////////////////
   apw_ctrl_t ctrl_r;
   logic flag_r;
   logic [5:0] trim_r;
   logic [15:0] rate_r;
   logic [5:0] nvm_s1_r;
   logic [5:0] nvm_s2_r;
   logic load_pend_r;
   logic wave_r;
   logic sq_r;
   logic [31:0] prdata_r;
   logic wr;
   logic rd;
   logic hit;
   logic osc_tick;
   logic tick;
   logic half;
   logic timeout;

   // One-cycle access: setup then access always completes
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign hit = (paddr[13:0] == APW_CTRL_ADDR) || (paddr[13:0] == APW_TRIM_ADDR) ||
                (paddr[13:0] == APW_RATE_ADDR);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Control register; select is frozen while enabled or being enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= '0;
      end else if (wr && paddr[13:0] == APW_CTRL_ADDR) begin
         if (!ctrl_r.feat_en && !pwdata[APW_FEN_BIT]) begin
            ctrl_r.clk_sel <= pwdata[APW_CLKSEL_BIT];
         end
         ctrl_r.wave_sel <= pwdata[APW_WAVESEL_BIT];
         ctrl_r.pin_en <= pwdata[APW_PINEN_BIT];
         ctrl_r.feat_en <= pwdata[APW_FEN_BIT];
         ctrl_r.irq_en <= pwdata[APW_IRQEN_BIT];
      end
   end

   // Sticky flag; a timeout in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else if (timeout) begin
         flag_r <= 1'b1;
      end else if (wr && paddr[13:0] == APW_CTRL_ADDR && pwdata[APW_FLAG_BIT]) begin
         flag_r <= 1'b0;
      end
   end

   assign periodic_irq = flag_r && ctrl_r.irq_en;

   ////////////////////////////////////////////////////////////////////////////////
   // Rate register, locked while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_r <= APW_RATE_RST;
      end else if (wr && paddr[13:0] == APW_RATE_ADDR && !ctrl_r.feat_en) begin
         rate_r <= pwdata[15:0];
      end
   end

   // Non-volatile value arrives from another domain: synchronise it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvm_s1_r <= 6'h00;
         nvm_s2_r <= 6'h00;
      end else begin
         nvm_s1_r <= nvm_trim;
         nvm_s2_r <= nvm_s1_r;
      end
   end

   // Load waits two edges so the synchroniser holds the real value
   logic [1:0] load_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_cnt_r <= 2'd0;
         load_pend_r <= 1'b1;
      end else if (load_pend_r) begin
         load_cnt_r <= load_cnt_r + 2'd1;
         if (load_cnt_r == 2'd2) begin
            load_pend_r <= 1'b0;
         end
      end
   end

   // Trim register: loaded after reset, then software writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_r <= APW_TRIM_RST;
      end else if (load_pend_r && load_cnt_r == 2'd2) begin
         trim_r <= nvm_s2_r;
      end else if (wr && paddr[13:0] == APW_TRIM_ADDR) begin
         trim_r <= pwdata[APW_TRIM_MSB:APW_TRIM_LSB];
      end
   end

   // Read mux, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr[13:0] == APW_CTRL_ADDR) begin
            prdata_r <= {24'h000000, ctrl_r.clk_sel, 2'b00, ctrl_r.wave_sel,
                         ctrl_r.pin_en, ctrl_r.feat_en, ctrl_r.irq_en, flag_r};
         end else if (paddr[13:0] == APW_TRIM_ADDR) begin
            prdata_r <= {24'h000000, trim_r, 2'b00};
         end else if (paddr[13:0] == APW_RATE_ADDR) begin
            prdata_r <= {16'h0000, rate_r};
         end else begin
            prdata_r <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   apw_osc u_osc (
      .pclk(pclk),
      .presetn(presetn),
      .trim(trim_r),
      .tick(osc_tick)
   );

   assign tick = ctrl_r.clk_sel ? 1'b1 : osc_tick;

   apw_cnt u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .run(ctrl_r.feat_en),
      .tick(tick),
      .rate(rate_r),
      .half(half),
      .timeout(timeout)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Square wave toggles per timeout; cleared while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sq_r <= 1'b0;
      end else if (!ctrl_r.feat_en) begin
         sq_r <= 1'b0;
      end else if (timeout) begin
         sq_r <= !sq_r;
      end
   end

   // Pulse: high from period end for one tick (half the minimum period)
   logic pulse_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_r <= 1'b0;
      end else if (!ctrl_r.feat_en) begin
         pulse_r <= 1'b0;
      end else if (timeout) begin
         pulse_r <= 1'b1;
      end else if (tick) begin
         pulse_r <= 1'b0;
      end
   end

   // Pin registered so it never glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_r <= 1'b0;
      end else if (ctrl_r.pin_en && ctrl_r.feat_en) begin
         wave_r <= ctrl_r.wave_sel ? sq_r : pulse_r;
      end else begin
         wave_r <= 1'b0;
      end
   end

   assign periodic_wave_pin = wave_r;
   logic unused_half;
   assign unused_half = half;
endmodule : apw_top

// ===== apw_pkg.sv
package apw_pkg;
   // Register byte addresses (trim printed at 0x2f3, not word aligned: index kept)
   localparam logic [11:0] APW_TRIM_IDX = 12'h2f3;
   localparam logic [11:0] APW_CTRL_IDX = 12'h2f2;
   localparam logic [11:0] APW_RATE_IDX = 12'h2f4;
   localparam logic [13:0] APW_TRIM_ADDR = {APW_TRIM_IDX, 2'b00};
   localparam logic [13:0] APW_CTRL_ADDR = {APW_CTRL_IDX, 2'b00};
   localparam logic [13:0] APW_RATE_ADDR = {APW_RATE_IDX, 2'b00};
   // Control field positions
   localparam int APW_CLKSEL_BIT = 7;
   localparam int APW_WAVESEL_BIT = 4;
   localparam int APW_PINEN_BIT = 3;
   localparam int APW_FEN_BIT = 2;
   localparam int APW_IRQEN_BIT = 1;
   localparam int APW_FLAG_BIT = 0;
   // Trim field position
   localparam int APW_TRIM_LSB = 2;
   localparam int APW_TRIM_MSB = 7;
   // Reset values
   localparam logic [15:0] APW_RATE_RST = 16'h0000;
   localparam logic [5:0] APW_TRIM_RST = 6'h00;
   // Oscillator tick generator: nominal divide from the bus clock, trimmed
   localparam logic [15:0] APW_OSC_DIV = 16'h2710;
   // Control fields as a carrier
   typedef struct packed {
      logic clk_sel;
      logic wave_sel;
      logic pin_en;
      logic feat_en;
      logic irq_en;
   } apw_ctrl_t;
endpackage : apw_pkg

// ===== apw_osc.sv
`timescale 1ns/10ps
// Low-frequency oscillator model: trimmed tick divider on the bus clock
module apw_osc
   import apw_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Trim and tick
   input wire logic [5:0] trim,
   output logic tick
);
   logic [15:0] cnt_r;
   logic [15:0] lim;
   // Bit 5 lengthens; lower bits shorten by binary weights
   always_comb begin
      lim = APW_OSC_DIV + (trim[5] ? 16'h0040 : 16'h0000) - {11'h000, trim[4:0]};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
      end else if (cnt_r >= lim - 16'h0001) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
   assign tick = (cnt_r == 16'h0000);
endmodule : apw_osc

// ===== apw_cnt.sv
`timescale 1ns/10ps
// Period counter: timeout every 2*(rate+1) count ticks
module apw_cnt
   import apw_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic tick,
   input wire logic [15:0] rate,
   // Events
   output logic half,
   output logic timeout
);
   logic [16:0] cnt_r;
   logic [16:0] last;
   assign last = {rate, 1'b1};
   assign timeout = run && tick && (cnt_r == last);
   assign half = run && tick && (cnt_r == 17'h00001);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 17'h00000;
      end else if (!run) begin
         cnt_r <= 17'h00000;
      end else if (timeout) begin
         cnt_r <= 17'h00000;
      end else if (tick) begin
         cnt_r <= cnt_r + 17'h00001;
      end
   end
endmodule : apw_cnt

// ===== apw_chk.sv
`timescale 1ns/10ps
module apw_chk
   import apw_pkg::*;
(
   // Bus side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Outputs
   input wire logic periodic_irq,
   input wire logic periodic_wave_pin
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   // Access decode, mirrored from the address map
   logic acc;
   logic mapped;
   assign acc = psel && penable;
   assign mapped = paddr inside {32'(APW_CTRL_ADDR), 32'(APW_TRIM_ADDR), 32'(APW_RATE_ADDR)};
   sequence s_ctrl_wr;
      acc && pwrite && paddr == 32'(APW_CTRL_ADDR);
   endsequence
   ////////////////////////////////////////////////////////////
   AST_NO_WAIT: assert property (acc |-> pready)
      else $error("access phase stalled");
   AST_UNMAPPED_ERR: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access not flagged");
   AST_MAPPED_OK: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access flagged");
   AST_UNMAPPED_RD0: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_TRIM_RD: assert property (acc && !pwrite && paddr == 32'(APW_TRIM_ADDR) |->
      prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0) else $error("trim low bits not zero");
   AST_IRQ_MASK: assert property (s_ctrl_wr ##0 !pwdata[APW_IRQEN_BIT] |=>
      !periodic_irq [*2]) else $error("request while masked");
   AST_FLAG_CLR: assert property (s_ctrl_wr ##0 pwdata[0] && !pwdata[APW_FEN_BIT] |=>
      !periodic_irq) else $error("flag survived write one");
   AST_PIN_OFF: assert property (s_ctrl_wr ##0 !(pwdata[3] && pwdata[2]) |->
      ##2 !periodic_wave_pin) else $error("pin driven while off");
endmodule : apw_chk
bind apw_top apw_chk apw_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .periodic_irq(periodic_irq),
   .periodic_wave_pin(periodic_wave_pin));

// ===== apw_pin_mon.sv
`timescale 1ns/10ps
// Pin receiver: rise-to-rise period and high width, in bus clocks
module apw_pin_mon (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin and figures
   input wire logic pin,
   output int per,
   output int wid
);
   int cnt;
   int hc;
   logic q;
   // Counts restart on every rise so a stalled pin shows stale figures
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= 1'b0; cnt <= 0; hc <= 0; per <= 0; wid <= 0;
      end else begin
         q <= pin;
         cnt <= (pin && !q) ? 1 : cnt + 1;
         hc <= pin ? hc + 1 : 0;
         if (pin && !q) per <= cnt;
         if (!pin && q) wid <= hc;
      end
   end
endmodule : apw_pin_mon

// ===== tb_apw_top.sv
`timescale 1ns/10ps
module tb_apw_top;
   import apw_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, r;
   logic pready, pslverr, periodic_irq, periodic_wave_pin, e;
   logic [5:0] nvm_trim = 6'h2a;
   int per, wid, failures = 0, n_tests = 0, cyc = 0;
   localparam logic [31:0] CA = 32'(APW_CTRL_ADDR), TA = 32'(APW_TRIM_ADDR);
   localparam logic [31:0] RA = 32'(APW_RATE_ADDR);
   apw_top apw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nvm_trim(nvm_trim), .periodic_irq(periodic_irq),
      .periodic_wave_pin(periodic_wave_pin));
   apw_pin_mon apw_pin_mon_inst (.pclk(pclk), .presetn(presetn), .pin(periodic_wave_pin),
      .per(per), .wid(wid));
   ////////////////////////////////////////////////////////////
   // Shared bus cycle and compare
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : xfer
   task final_report;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////
   // Scenarios
   task t_trim;
      xfer(0, TA, 0); chk("trim load", r, 32'ha8);
      xfer(1, TA, 32'hff); xfer(0, TA, 0); chk("trim rd", r, 32'hfc);
      xfer(0, 32'hbd4, 0); chk("unmapped err", {31'h0, e}, 32'h1);
   endtask : t_trim
   task t_pulse;
      xfer(1, RA, 32'h3); xfer(1, CA, 32'h80); xfer(1, CA, 32'h8c);
      repeat (40) @(posedge pclk);
      chk("pulse period", per, 32'd8);
      chk("pulse width", wid, 32'd1);
      xfer(1, RA, 32'h0); xfer(0, RA, 0); chk("rate locked", r, 32'h3);
      xfer(0, CA, 0); chk("flag set", r, 32'h8d);
   endtask : t_pulse
   task t_square;
      xfer(1, CA, 32'h80); xfer(1, CA, 32'h9c);
      repeat (60) @(posedge pclk);
      chk("square period", per, 32'd16);
      chk("square width", wid, 32'd8);
      xfer(1, CA, 32'h1c); xfer(0, CA, 0); chk("sel locked", r[7], 1'b1);
      xfer(1, CA, 32'h80); xfer(1, CA, 32'h0c); xfer(0, CA, 0);
      chk("sel with enable", r[7], 1'b1);
   endtask : t_square
   task t_irq;
      // Sample on the falling edge, once the registered pin has settled
      xfer(1, CA, 32'h82); @(posedge pclk); @(negedge pclk);
      chk("irq on", periodic_irq, 1'b1);
      chk("pin off", periodic_wave_pin, 1'b0);
      xfer(1, CA, 32'h83); @(posedge pclk); @(negedge pclk);
      chk("irq cleared", periodic_irq, 1'b0);
      xfer(0, CA, 0); chk("ctrl after clear", r, 32'h82);
   endtask : t_irq
   task t_osc;
      xfer(1, CA, 32'h00); xfer(1, CA, 32'h0c);
      repeat (1000) @(posedge pclk);
      xfer(0, CA, 0); chk("slow clock quiet", r, 32'h0c);
      xfer(1, CA, 32'h00); xfer(0, CA, 0); chk("stopped", r, 32'h0);
   endtask : t_osc
   ////////////////////////////////////////////////////////////
   // Clock, hang limit and main sequence
   initial forever #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         final_report;
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      t_trim;
      t_pulse;
      t_square;
      t_irq;
      t_osc;
      final_report;
   end
endmodule : tb_apw_top
